// ---- include/epc_pkg.sv ----
// Purpose: Constants for the exception pending control block
// Assumes: One 32-bit control and state word at a fixed offset
// Notes: Bits outside 28:18 belong to neighbouring logic and read as zero here
package epc_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] EPC_ICS_OFFSET = 12'hD04;
    localparam logic [31:0] EPC_ICS_RESET = 32'h0000_0000;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int EPC_DC_SET_BIT = 28;
    localparam int EPC_DC_CLR_BIT = 27;
    localparam int EPC_TK_SET_BIT = 26;
    localparam int EPC_TK_CLR_BIT = 25;
    localparam int EPC_DBG_IRQ_BIT = 23;
    localparam int EPC_ANY_IRQ_BIT = 22;
    localparam int EPC_RSVD_BIT = 24;
    localparam int EPC_RSVD_LO_MSB = 21;
    localparam int EPC_RSVD_LO_LSB = 18;
    localparam logic EPC_PEND_RESET = 1'h0;
    // ****************************************
    // Access result
    // ****************************************
    typedef enum logic [1:0] {EPC_ACC_NONE, EPC_ACC_OK, EPC_ACC_DENIED} epc_acc_t;
endpackage

// ---- include/epc_if.sv ----
// Purpose: Carries decoded write strobes between the bus front and pending flags
// Assumes: Strobes are single-cycle pulses
// Notes: One interface instance per exception source
`timescale 1ns/1ps
interface epc_pend_if;
    logic set_pulse;
    logic clr_pulse;
    logic entry_pulse;
    logic pending;
    modport ctl (output set_pulse, output clr_pulse, output entry_pulse, input pending);
    modport flag (input set_pulse, input clr_pulse, input entry_pulse, output pending);
endinterface

// ---- logic/epc_pend_flag.sv ----
// Purpose: One sticky pending flag with set, clear and handler-entry clear
// Assumes: Caller never sets and clears in one write
// Notes: A set in the same cycle as a clear wins so no event is lost
`timescale 1ns/1ps
module epc_pend_flag (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Strobes
    epc_pend_if.flag pif
);
    import epc_pkg::*;
    logic pend_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_q <= EPC_PEND_RESET;
        end else if (pif.set_pulse) begin
            pend_q <= 1'h1;
        end else if (pif.clr_pulse || pif.entry_pulse) begin
            pend_q <= 1'h0;
        end
    end
    assign pif.pending = pend_q;
endmodule

// ---- logic/epc_top.sv ----
// Purpose: Set, clear and status bits 28:18 of the interrupt control and state word
// Assumes: Word accesses from the system control space, one cycle per access
// Notes: Privilege checked here; denied accesses raise o_acc_err
//
// What this block does
// - A one written to bit 28 makes the deferred service call pending; a zero does nothing.
// - Bit 28 reads one while the deferred service call is pending.
// - Only a write of bit 28 can make the deferred service call pending.
// - A one written to bit 27 removes the deferred call pending state; a zero does nothing.
// - A one written to bit 26 makes the tick pending, reads of it show that state.
// - The tick pending state reads as one when pending and zero otherwise.
// - A one written to bit 25 clears the tick pending state shown on bit 26.
// - The tick pending state drops only through bit 25 or tick handler entry (i_tk_entry), never through bit 26.
// - Bit 23 tells, in debug mode only, whether release from halt takes an interrupt.
// - Outside debug mode bit 23 reads zero.
// - Bit 22 reads one when any ordinary interrupt is pending, ignoring NMI and faults.
// - Only privileged accesses reach the register; others are refused.
`timescale 1ns/1ps
module epc_top (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Register access
    input wire logic i_sel,
    input wire logic i_wr,
    input wire logic i_priv,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_rdata,
    output logic o_ack,
    output logic o_acc_err,
    // Core status
    input wire logic i_debug_mode,
    input wire logic i_halt_release_irq,
    input wire logic i_irq_pending,
    input wire logic i_dc_entry,
    input wire logic i_tk_entry,
    // Pending to exception logic
    output logic o_dc_pending,
    output logic o_tk_pending
);
    import epc_pkg::*;

    // ****************************************
    // Reset release
    // ****************************************
    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_q <= 1'h0;
            rst_n_q <= 1'h0;
        end else begin
            rst_meta_q <= 1'h1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ****************************************
    // Access decode
    // ****************************************
    function automatic epc_acc_t decode(input logic sel, input logic priv,
                                        input logic [11:0] addr);
        if (!sel || addr != EPC_ICS_OFFSET) begin
            return EPC_ACC_NONE;
        end
        return priv ? EPC_ACC_OK : EPC_ACC_DENIED;
    endfunction

    epc_acc_t acc;
    logic wr_ok;
    assign acc = decode(i_sel, i_priv, i_addr);
    assign wr_ok = (acc == EPC_ACC_OK) && i_wr;

    epc_pend_if dc_if ();
    epc_pend_if tk_if ();

    // Set strobes only from bus writes, no other source
    assign dc_if.set_pulse = wr_ok && i_wdata[EPC_DC_SET_BIT];
    assign dc_if.clr_pulse = wr_ok && i_wdata[EPC_DC_CLR_BIT];
    assign dc_if.entry_pulse = i_dc_entry;
    assign tk_if.set_pulse = wr_ok && i_wdata[EPC_TK_SET_BIT];
    // Set bit never clears; only the clear bit or entry does
    assign tk_if.clr_pulse = wr_ok && i_wdata[EPC_TK_CLR_BIT];
    assign tk_if.entry_pulse = i_tk_entry;

    // ****************************************
    // Pending flags
    // ****************************************
    epc_pend_flag u_dc_flag (
        .i_clk(i_mclk),
        .i_rst_n(rst_n_q),
        .pif(dc_if.flag)
    );
    epc_pend_flag u_tk_flag (
        .i_clk(i_mclk),
        .i_rst_n(rst_n_q),
        .pif(tk_if.flag)
    );
    assign o_dc_pending = dc_if.pending;
    assign o_tk_pending = tk_if.pending;

    // ****************************************
    // Read data
    // ****************************************
    logic [31:0] rd_d;
    always_comb begin
        // Clear bits, reserved bits and neighbours read zero
        rd_d = EPC_ICS_RESET;
        rd_d[EPC_DC_SET_BIT] = dc_if.pending;
        rd_d[EPC_TK_SET_BIT] = tk_if.pending;
        rd_d[EPC_DBG_IRQ_BIT] = i_debug_mode && i_halt_release_irq;
        rd_d[EPC_ANY_IRQ_BIT] = i_irq_pending;
    end

    // Denied reads return zero so user code learns nothing
    always_ff @(posedge i_mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_rdata <= EPC_ICS_RESET;
        end else if (acc == EPC_ACC_OK && !i_wr) begin
            o_rdata <= rd_d;
        end else begin
            o_rdata <= EPC_ICS_RESET;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_ack <= 1'h0;
            o_acc_err <= 1'h0;
        end else begin
            o_ack <= (acc == EPC_ACC_OK);
            o_acc_err <= (acc == EPC_ACC_DENIED);
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_dc_set;
        @(posedge i_mclk) disable iff (!rst_n_q)
        dc_if.set_pulse |=> o_dc_pending;
    endproperty
    a_dc_set: assert property (p_dc_set) else $error("dc set lost");

    property p_dc_read;
        @(posedge i_mclk) disable iff (!rst_n_q)
        (acc == EPC_ACC_OK && !i_wr) |=> (o_rdata[EPC_DC_SET_BIT] == $past(o_dc_pending));
    endproperty
    a_dc_read: assert property (p_dc_read) else $error("dc read wrong");

    property p_dc_only_set;
        @(posedge i_mclk) disable iff (!rst_n_q)
        $rose(o_dc_pending) |-> $past(wr_ok && i_wdata[EPC_DC_SET_BIT]);
    endproperty
    a_dc_only_set: assert property (p_dc_only_set) else $error("dc set by other");

    property p_dc_clr;
        @(posedge i_mclk) disable iff (!rst_n_q)
        (wr_ok && i_wdata[EPC_DC_CLR_BIT] && !i_wdata[EPC_DC_SET_BIT]) |=> !o_dc_pending;
    endproperty
    a_dc_clr: assert property (p_dc_clr) else $error("dc clear failed");

    property p_tk_set;
        @(posedge i_mclk) disable iff (!rst_n_q)
        tk_if.set_pulse |=> o_tk_pending;
    endproperty
    a_tk_set: assert property (p_tk_set) else $error("tick set lost");

    property p_tk_read;
        @(posedge i_mclk) disable iff (!rst_n_q)
        (acc == EPC_ACC_OK && !i_wr) |=> (o_rdata[EPC_TK_SET_BIT] == $past(o_tk_pending));
    endproperty
    a_tk_read: assert property (p_tk_read) else $error("tick read wrong");

    property p_tk_clr;
        @(posedge i_mclk) disable iff (!rst_n_q)
        (wr_ok && i_wdata[EPC_TK_CLR_BIT] && !i_wdata[EPC_TK_SET_BIT]) |=> !o_tk_pending;
    endproperty
    a_tk_clr: assert property (p_tk_clr) else $error("tick clear failed");

    property p_tk_fall;
        @(posedge i_mclk) disable iff (!rst_n_q)
        $fell(o_tk_pending) |-> $past(tk_if.clr_pulse || i_tk_entry);
    endproperty
    a_tk_fall: assert property (p_tk_fall) else $error("tick dropped wrongly");

    property p_dbg_bit;
        @(posedge i_mclk) disable iff (!rst_n_q)
        (acc == EPC_ACC_OK && !i_wr && !i_debug_mode) |=> !o_rdata[EPC_DBG_IRQ_BIT];
    endproperty
    a_dbg_bit: assert property (p_dbg_bit) else $error("debug bit outside debug");

    property p_dbg_val;
        @(posedge i_mclk) disable iff (!rst_n_q)
        (acc == EPC_ACC_OK && !i_wr && i_debug_mode)
            |=> (o_rdata[EPC_DBG_IRQ_BIT] == $past(i_halt_release_irq));
    endproperty
    a_dbg_val: assert property (p_dbg_val) else $error("debug bit wrong");

    property p_any_irq;
        @(posedge i_mclk) disable iff (!rst_n_q)
        (acc == EPC_ACC_OK && !i_wr) |=> (o_rdata[EPC_ANY_IRQ_BIT] == $past(i_irq_pending));
    endproperty
    a_any_irq: assert property (p_any_irq) else $error("irq pending bit wrong");

    property p_rsvd;
        @(posedge i_mclk) disable iff (!rst_n_q)
        !o_rdata[EPC_RSVD_BIT] && o_rdata[EPC_RSVD_LO_MSB:EPC_RSVD_LO_LSB] == 4'h0
            && !o_rdata[EPC_DC_CLR_BIT] && !o_rdata[EPC_TK_CLR_BIT];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

    property p_denied;
        @(posedge i_mclk) disable iff (!rst_n_q)
        (acc == EPC_ACC_DENIED) |=> (o_acc_err && !o_ack && o_rdata == 32'h0);
    endproperty
    a_denied: assert property (p_denied) else $error("user access not refused");

    property p_entry;
        @(posedge i_mclk) disable iff (!rst_n_q)
        (i_dc_entry && !dc_if.set_pulse) |=> !o_dc_pending;
    endproperty
    a_entry: assert property (p_entry) else $error("entry did not clear");

    // ****************************************
    // Entry, edge, hold, access and reset checks
    // ****************************************
    property p_tk_entry;
        @(posedge i_mclk) disable iff (!rst_n_q)
        (i_tk_entry && !tk_if.set_pulse) |=> !o_tk_pending;
    endproperty
    a_tk_entry: assert property (p_tk_entry) else $error("tick entry did not clear");

    property p_dc_fall;
        @(posedge i_mclk) disable iff (!rst_n_q)
        $fell(o_dc_pending) |-> $past(dc_if.clr_pulse || i_dc_entry);
    endproperty
    a_dc_fall: assert property (p_dc_fall) else $error("dc dropped wrongly");

    property p_tk_rise;
        @(posedge i_mclk) disable iff (!rst_n_q)
        $rose(o_tk_pending) |-> $past(tk_if.set_pulse);
    endproperty
    a_tk_rise: assert property (p_tk_rise) else $error("tick set by other");

    property p_dc_hold;
        @(posedge i_mclk) disable iff (!rst_n_q)
        (!dc_if.set_pulse && !dc_if.clr_pulse && !i_dc_entry) |=> $stable(o_dc_pending);
    endproperty
    a_dc_hold: assert property (p_dc_hold) else $error("dc moved without strobe");

    property p_tk_hold;
        @(posedge i_mclk) disable iff (!rst_n_q)
        (!tk_if.set_pulse && !tk_if.clr_pulse && !i_tk_entry) |=> $stable(o_tk_pending);
    endproperty
    a_tk_hold: assert property (p_tk_hold) else $error("tick moved without strobe");

    property p_ack;
        @(posedge i_mclk) disable iff (!rst_n_q)
        (acc == EPC_ACC_OK) |=> (o_ack && !o_acc_err);
    endproperty
    a_ack: assert property (p_ack) else $error("access not acknowledged");

    property p_err_ok;
        @(posedge i_mclk) disable iff (!rst_n_q)
        (acc != EPC_ACC_DENIED) |=> !o_acc_err;
    endproperty
    a_err_ok: assert property (p_err_ok) else $error("stray access error");

    property p_unmapped;
        @(posedge i_mclk) disable iff (!rst_n_q)
        (acc == EPC_ACC_NONE) |=> (!o_ack && o_rdata == EPC_ICS_RESET);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access answered");

    property p_rd_idle;
        @(posedge i_mclk) disable iff (!rst_n_q)
        !(acc == EPC_ACC_OK && !i_wr) |=> (o_rdata == EPC_ICS_RESET);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero");

    property p_denied_keep;
        @(posedge i_mclk) disable iff (!rst_n_q)
        (acc == EPC_ACC_DENIED && !i_dc_entry && !i_tk_entry)
            |=> ($stable(o_dc_pending) && $stable(o_tk_pending));
    endproperty
    a_denied_keep: assert property (p_denied_keep) else $error("denied moved flag");

    // Checked without disable so the reset state itself is watched
    property p_rst_quiet;
        @(posedge i_mclk)
        !rst_n_q |-> (!o_dc_pending && !o_tk_pending && !o_ack && !o_acc_err);
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset");

    c_dc_set: cover property (@(posedge i_mclk) disable iff (!rst_n_q) $rose(o_dc_pending));
    c_tk_clr: cover property (@(posedge i_mclk) disable iff (!rst_n_q) $fell(o_tk_pending));
    c_denied: cover property (@(posedge i_mclk) disable iff (!rst_n_q) o_acc_err);
    c_back: cover property (@(posedge i_mclk) disable iff (!rst_n_q) o_ack ##1 o_ack);
    c_entry: cover property (@(posedge i_mclk) disable iff (!rst_n_q)
        o_tk_pending ##1 i_tk_entry ##1 !o_tk_pending);
endmodule

// ---- bench/epc_top_tb.sv ----
// Purpose: Self-checking bench for the exception pending control word
// Assumes: One access per cycle, inputs driven on the falling edge
// Notes: Expected words are built from field positions, never from outputs
`timescale 1ns/1ps
module epc_top_tb;
    import epc_pkg::*;
    // ****************************************
    // Stimulus and state
    // ****************************************
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_sel = 1'b0;
    logic i_wr = 1'b0;
    logic i_priv = 1'b0;
    logic [11:0] i_addr = 12'h000;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_debug_mode = 1'b0;
    logic i_halt_release_irq = 1'b0;
    logic i_irq_pending = 1'b0;
    logic i_dc_entry = 1'b0;
    logic i_tk_entry = 1'b0;
    logic [31:0] o_rdata;
    logic o_ack;
    logic o_acc_err;
    logic o_dc_pending;
    logic o_tk_pending;
    logic ack_s;
    logic err_s;
    logic [31:0] rd_s;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    always #12.5 i_mclk = ~i_mclk;
    epc_top u_epc_top (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_sel(i_sel), .i_wr(i_wr),
        .i_priv(i_priv), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .o_ack(o_ack), .o_acc_err(o_acc_err), .i_debug_mode(i_debug_mode),
        .i_halt_release_irq(i_halt_release_irq), .i_irq_pending(i_irq_pending),
        .i_dc_entry(i_dc_entry), .i_tk_entry(i_tk_entry), .o_dc_pending(o_dc_pending),
        .o_tk_pending(o_tk_pending));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic [31:0] bit_w(input int pos);
        return 32'h0000_0001 << pos;
    endfunction
    function automatic logic [31:0] word(input logic dc, tk, dbg, irq);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[EPC_DC_SET_BIT] = dc;
        w[EPC_TK_SET_BIT] = tk;
        w[EPC_DBG_IRQ_BIT] = dbg;
        w[EPC_ANY_IRQ_BIT] = irq;
        return w;
    endfunction
    // Holds select up so back-to-back calls need no idle cycle
    task automatic access(input logic we, priv, input logic [11:0] addr, input logic [31:0] wd);
        i_sel = 1'b1;
        i_wr = we;
        i_priv = priv;
        i_addr = addr;
        i_wdata = wd;
        @(negedge i_mclk);
        ack_s = o_ack;
        err_s = o_acc_err;
        rd_s = o_rdata;
    endtask
    task automatic idle();
        i_sel = 1'b0;
        @(negedge i_mclk);
    endtask
    task automatic wr(input logic [31:0] wd);
        access(1'b1, 1'b1, EPC_ICS_OFFSET, wd);
        check("write ack", {31'h0, ack_s}, 32'h1);
        check("write err", {31'h0, err_s}, 32'h0);
        check("write rdata", rd_s, 32'h0000_0000);
    endtask
    task automatic rd(input logic [31:0] exp);
        access(1'b0, 1'b1, EPC_ICS_OFFSET, 32'h0000_0000);
        check("read ack", {31'h0, ack_s}, 32'h1);
        check("read err", {31'h0, err_s}, 32'h0);
        check("read word", rd_s, exp);
    endtask
    task automatic pend(input logic dc, tk);
        check("dc pending", {31'h0, o_dc_pending}, {31'h0, dc});
        check("tk pending", {31'h0, o_tk_pending}, {31'h0, tk});
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        repeat (10) @(negedge i_mclk);
        i_resetn = 1'b1;
        repeat (3) @(negedge i_mclk);
        rd(word(0, 0, 0, 0));
        wr(32'h0000_0000);
        pend(0, 0);
        wr(bit_w(EPC_TK_SET_BIT));
        pend(0, 1);
        wr(bit_w(EPC_DC_SET_BIT));
        rd(word(1, 1, 0, 0));
        wr(32'h0000_0000);
        wr(bit_w(EPC_TK_SET_BIT));
        pend(1, 1);
        wr(bit_w(EPC_DC_CLR_BIT));
        rd(word(0, 1, 0, 0));
        wr(bit_w(EPC_TK_CLR_BIT));
        rd(word(0, 0, 0, 0));
        access(1'b1, 1'b0, EPC_ICS_OFFSET, bit_w(EPC_DC_SET_BIT));
        check("denied", {30'h0, err_s, ack_s}, 32'h2);
        access(1'b0, 1'b0, EPC_ICS_OFFSET, 32'h0000_0000);
        check("denied rdata", rd_s, 32'h0000_0000);
        check("denied read", {30'h0, err_s, ack_s}, 32'h2);
        access(1'b1, 1'b1, EPC_ICS_OFFSET + 12'h004, bit_w(EPC_DC_SET_BIT));
        check("unmapped", {30'h0, err_s, ack_s}, 32'h0);
        pend(0, 0);
        // Covers every mix of debug mode, halt release and pending irq
        for (int k = 0; k < 8; k++) begin
            {i_debug_mode, i_halt_release_irq, i_irq_pending} = k[2:0];
            rd(word(0, 0, k[2] & k[1], k[0]));
        end
        // Status inputs back to idle so later reads expect a clean word
        {i_debug_mode, i_halt_release_irq, i_irq_pending} = 3'h0;
        wr(bit_w(EPC_DC_SET_BIT));
        wr(bit_w(EPC_TK_SET_BIT));
        idle();
        i_dc_entry = 1'b1;
        @(negedge i_mclk);
        i_dc_entry = 1'b0;
        pend(0, 1);
        i_tk_entry = 1'b1;
        @(negedge i_mclk);
        i_tk_entry = 1'b0;
        pend(0, 0);
        // Handler entry in the same cycle as a set write: the set wins
        i_dc_entry = 1'b1;
        wr(bit_w(EPC_DC_SET_BIT));
        i_dc_entry = 1'b0;
        pend(1, 0);
        wr(bit_w(EPC_DC_SET_BIT));
        idle();
        i_resetn = 1'b0;
        #1;
        pend(0, 0);
        check("reset strobes", {30'h0, o_acc_err, o_ack}, 32'h0);
        check("reset rdata", o_rdata, 32'h0000_0000);
        repeat (2) @(negedge i_mclk);
        i_resetn = 1'b1;
        repeat (3) @(negedge i_mclk);
        rd(word(0, 0, 0, 0));
        idle();
        print_verdict();
    end
endmodule
